// file: design/dsq_pkg.sv
// Constants, types and helpers shared by the drum sequencer control block.
// Assumes one 50 MHz clock and a synchronous active-low reset in every user.

package dsq_pkg;

	// ==========================================
	// Sizes and counts
	localparam int NSEL = 8;
	localparam int NPAT = 64;
	localparam int NSONG = 16;
	localparam int SONG_SLOTS = 32;
	localparam logic [3:0] CHAIN_MAX = 4'h8;
	localparam logic [3:0] LAST_STEP_DEF = 4'hf;
	localparam logic [4:0] SONG_LEN_DEF = 5'h18;
	localparam logic [7:0] SEL_ONE = 8'h01;

	// ==========================================
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;

	// ==========================================
	// Load port kinds
	localparam logic [1:0] LD_STEP = 2'h0;
	localparam logic [1:0] LD_PLEN = 2'h1;
	localparam logic [1:0] LD_SONG = 2'h2;
	localparam logic [1:0] LD_SLEN = 2'h3;

	// ==========================================
	// Types
	typedef enum logic [7:0] {
		DSQ_M_DRUMS = 8'h01,
		DSQ_M_PATS = 8'h02,
		DSQ_M_SONGS = 8'h04,
		DSQ_M_SEL4 = 8'h08,
		DSQ_M_SEL5 = 8'h10,
		DSQ_M_SEL6 = 8'h20,
		DSQ_M_SEL7 = 8'h40,
		DSQ_M_SEL8 = 8'h80
	} dsq_mode_t;

	typedef struct packed {
		logic mode;
		logic sec;
		logic tog;
		logic run;
		logic [7:0] sel;
	} dsq_btn_t;

	typedef struct packed {
		logic [7:0] sel;
		logic tog;
		logic half;
		logic run;
	} dsq_led_t;

	typedef struct packed {
		logic we;
		logic [1:0] kind;
		logic [9:0] addr;
		logic [7:0] data;
	} dsq_load_t;

	// Lowest pressed selector wins when two edges coincide
	function automatic logic [2:0] dsq_idx(input logic [7:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = NSEL - 1; i >= 0; i--)
		begin
			if (v[i])
				r = 3'(i);
		end
		return r;
	endfunction

endpackage

// file: design/dsq_btn_sync.sv
// Two-flop synchroniser plus press-edge detector for button pins.
// Assumes raw pins are asynchronous to sys_clk_i and already debounced.
`timescale 1ns/10ps

module dsq_btn_sync #(
	parameter int W = 12
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Pins
	input wire logic [W-1:0] raw_i,
	// Synced level and press pulse
	output logic [W-1:0] lvl_o,
	output logic [W-1:0] rise_o
);

	logic [W-1:0] meta_ff, sync_ff, prev_ff;
	logic [W-1:0] nxt_meta, nxt_sync, nxt_prev;

	// Only sync_ff reads meta_ff
	always_comb
	begin
		nxt_meta = raw_i;
		nxt_sync = meta_ff;
		nxt_prev = sync_ff;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end
		else
		begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
		end
	end

	assign lvl_o = sync_ff;
	assign rise_o = sync_ff & ~prev_ff;

endmodule

// file: design/dsq_top.sv
// Mode control and playback sequencer for an eight-voice drum instrument.
// Assumes tempo_tick_i is a one-cycle pulse on sys_clk_i; buttons are pins.
`timescale 1ns/10ps

module dsq_top
	import dsq_pkg::*;
#(
	parameter int BLINK_CYCLES = BLINK_CYC
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Buttons (pins) and tempo step pulse
	input wire dsq_btn_t btn_i,
	input wire logic tempo_tick_i,
	// Pattern and song memory load
	input wire dsq_load_t load_i,
	// Drum triggers and lamps
	output logic [7:0] trig_o,
	output dsq_led_t led_o
);

	// ==========================================
	// Button conditioning
	dsq_btn_t b, e;

	dsq_btn_sync #(.W($bits(dsq_btn_t))) u_sync (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.raw_i(btn_i),
		.lvl_o(b),
		.rise_o(e)
	);

	// ==========================================
	// Pattern and song storage
	logic [7:0] pat_mem [NPAT*16];
	logic [3:0] plen_mem [NPAT];
	logic [5:0] song_mem [NSONG*SONG_SLOTS];
	logic [4:0] slen_mem [NSONG];

	// Pattern lengths reset to full, song lengths to 24, so playback is sane before loading
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			for (int i = 0; i < NPAT; i++)
				plen_mem[i] <= LAST_STEP_DEF;
			for (int i = 0; i < NSONG; i++)
				slen_mem[i] <= SONG_LEN_DEF;
		end
		else if (load_i.we)
		begin
			case (load_i.kind)
				LD_STEP: pat_mem[load_i.addr] <= load_i.data;
				LD_PLEN: plen_mem[load_i.addr[5:0]] <= load_i.data[3:0];
				LD_SONG: song_mem[load_i.addr[8:0]] <= load_i.data[5:0];
				default: slen_mem[load_i.addr[3:0]] <= load_i.data[4:0];
			endcase
		end
	end

	// ==========================================
	// State
	dsq_mode_t mode_ff, nxt_mode;
	logic tempo_ff, ovl_ff, fsel_ff, run_ff, stopq_ff, sply_ff;
	logic nxt_tempo, nxt_ovl, nxt_fsel, nxt_run, nxt_stopq, nxt_sply;
	logic [2:0] pbank_ff, nxt_pbank, cbank_ff, nxt_cbank;
	logic sbank_ff, nxt_sbank;
	logic [3:0] step_ff, nxt_step;
	logic [5:0] cur_ff, nxt_cur, npat_ff, nxt_npat;
	logic ppend_ff, nxt_ppend;
	logic [2:0] chain_ff [8];
	logic [2:0] nxt_chain [8];
	logic [3:0] clen_ff, nxt_clen, bld_ff, nxt_bld;
	logic [2:0] cidx_ff, nxt_cidx;
	logic cact_ff, nxt_cact, cpend_ff, nxt_cpend;
	logic [3:0] song_ff, nxt_song, snew_ff, nxt_snew;
	logic spend_ff, nxt_spend;
	logic [4:0] spos_ff, nxt_spos;
	logic [5:0] fill_ff, nxt_fill;
	logic fpend_ff, nxt_fpend, infill_ff, nxt_infill, intro_ff, nxt_intro;
	logic [7:0] trig_ff, nxt_trig;
	dsq_led_t led_ff, nxt_led;
	logic [23:0] bcnt_ff, nxt_bcnt;
	logic blink_ff, nxt_blink;

	// ==========================================
	// Helpers
	logic [2:0] si;
	logic hit, plain, held_before, pat_end;
	logic [4:0] pos_inc;
	logic [2:0] cidx_inc;

	assign si = dsq_idx(e.sel);
	assign hit = |e.sel;
	assign plain = !b.mode && !b.sec;
	assign held_before = |(b.sel & ~e.sel);
	// Ends are judged on the step boundary
	assign pat_end = run_ff && tempo_tick_i && (step_ff == plen_mem[cur_ff]);
	assign pos_inc = (spos_ff + 5'h1 >= slen_mem[song_ff]) ? 5'h0 : spos_ff + 5'h1;
	assign cidx_inc = ({1'b0, cidx_ff} + 4'h1 >= clen_ff) ? 3'h0 : cidx_ff + 3'h1;

	// ==========================================
	// Next-state logic
	always_comb
	begin
		nxt_mode = mode_ff;
		nxt_tempo = tempo_ff;
		nxt_ovl = ovl_ff;
		nxt_fsel = fsel_ff;
		nxt_run = run_ff;
		nxt_stopq = stopq_ff;
		nxt_sply = sply_ff;
		nxt_pbank = pbank_ff;
		nxt_cbank = cbank_ff;
		nxt_sbank = sbank_ff;
		nxt_step = step_ff;
		nxt_cur = cur_ff;
		nxt_npat = npat_ff;
		nxt_ppend = ppend_ff;
		nxt_chain = chain_ff;
		nxt_clen = clen_ff;
		nxt_bld = bld_ff;
		nxt_cidx = cidx_ff;
		nxt_cact = cact_ff;
		nxt_cpend = cpend_ff;
		nxt_song = song_ff;
		nxt_snew = snew_ff;
		nxt_spend = spend_ff;
		nxt_spos = spos_ff;
		nxt_fill = fill_ff;
		nxt_fpend = fpend_ff;
		nxt_infill = infill_ff;
		nxt_intro = intro_ff;
		nxt_trig = 8'h00;

		// Mode switch only while the mode button is held
		if (b.mode && hit)
			nxt_mode = dsq_mode_t'(SEL_ONE << si);

		// Toggle button meaning depends on mode
		if (e.tog && !b.mode)
		begin
			case (mode_ff)
				DSQ_M_DRUMS: nxt_tempo = !tempo_ff;
				DSQ_M_PATS: nxt_ovl = !ovl_ff;
				DSQ_M_SONGS: nxt_fsel = !fsel_ff;
				default: ;
			endcase
		end

		// Bank choice under the secondary button
		if (b.sec && !b.mode && hit)
		begin
			if (mode_ff == DSQ_M_PATS || (mode_ff == DSQ_M_SONGS && fsel_ff))
				nxt_pbank = si;
			else if (mode_ff == DSQ_M_SONGS && si < 3'h2)
				nxt_sbank = si[0];
		end

		// Step position
		if (run_ff && tempo_tick_i)
			nxt_step = pat_end ? 4'h0 : step_ff + 4'h1;

		// Pattern picks and chain building
		if (mode_ff == DSQ_M_PATS && plain && !ovl_ff && hit)
		begin
			if (!held_before)
			begin
				nxt_chain[0] = si;
				nxt_bld = 4'h1;
				nxt_cact = 1'b0;
				nxt_cpend = 1'b0;
				if (!run_ff)
				begin
					nxt_cur = {pbank_ff, si};
					nxt_ppend = 1'b0;
				end
				else if ({pbank_ff, si} != cur_ff)
				begin
					nxt_npat = {pbank_ff, si};
					nxt_ppend = 1'b1;
				end
				else
					nxt_ppend = 1'b0;
			end
			else if (bld_ff < CHAIN_MAX)
			begin
				nxt_chain[bld_ff[2:0]] = si;
				nxt_bld = bld_ff + 4'h1;
			end
		end

		// Release of all selectors closes the chain
		if (b.sel == 8'h00 && bld_ff != 4'h0)
		begin
			nxt_bld = 4'h0;
			if (bld_ff > 4'h1)
			begin
				nxt_clen = bld_ff;
				nxt_cbank = pbank_ff;
				nxt_ppend = 1'b0;
				if (run_ff)
					nxt_cpend = 1'b1;
				else
				begin
					nxt_cact = 1'b1;
					nxt_cidx = 3'h0;
					nxt_cur = {pbank_ff, chain_ff[0]};
				end
			end
		end

		// Song and fill picks
		if (mode_ff == DSQ_M_SONGS && plain && hit)
		begin
			if (fsel_ff)
			begin
				nxt_fill = {pbank_ff, si};
				nxt_fpend = 1'b1;
			end
			else if (!run_ff)
			begin
				nxt_song = {sbank_ff, si};
				nxt_spend = 1'b0;
			end
			else if ({sbank_ff, si} != song_ff)
			begin
				nxt_snew = {sbank_ff, si};
				nxt_spend = 1'b1;
			end
		end

		// Pattern boundary: deferred stops and switches
		if (pat_end)
		begin
			if (stopq_ff)
			begin
				nxt_run = 1'b0;
				nxt_stopq = 1'b0;
			end
			if (!sply_ff)
			begin
				if (cpend_ff)
				begin
					nxt_cact = 1'b1;
					nxt_cpend = 1'b0;
					nxt_cidx = 3'h0;
					nxt_cur = {cbank_ff, chain_ff[0]};
				end
				else if (ppend_ff)
				begin
					nxt_cur = npat_ff;
					nxt_ppend = 1'b0;
				end
				else if (cact_ff)
				begin
					nxt_cidx = cidx_inc;
					nxt_cur = {cbank_ff, chain_ff[cidx_inc]};
				end
			end
			else if (spend_ff)
			begin
				nxt_song = snew_ff;
				nxt_spend = 1'b0;
				nxt_spos = 5'h0;
				nxt_infill = 1'b0;
				nxt_cur = song_mem[{snew_ff, 5'h0}];
			end
			else if (fpend_ff)
			begin
				nxt_cur = fill_ff;
				nxt_fpend = 1'b0;
				nxt_infill = 1'b1;
			end
			else
			begin
				// After an intro the song starts at its first entry
				nxt_spos = (infill_ff && intro_ff) ? 5'h0 : pos_inc;
				nxt_cur = song_mem[{song_ff, nxt_spos}];
				nxt_infill = 1'b0;
				nxt_intro = 1'b0;
			end
		end

		// Run button; overrides a boundary in the same cycle
		if (e.run && !b.mode)
		begin
			if (run_ff)
			begin
				if (b.tog)
				begin
					nxt_run = 1'b0;
					nxt_stopq = 1'b0;
				end
				else
					nxt_stopq = 1'b1;
			end
			else
			begin
				nxt_run = 1'b1;
				nxt_stopq = 1'b0;
				if (!b.tog)
				begin
					nxt_step = 4'h0;
					nxt_sply = (mode_ff == DSQ_M_SONGS);
					if (mode_ff == DSQ_M_SONGS)
					begin
						nxt_spos = 5'h0;
						nxt_infill = fpend_ff;
						nxt_intro = fpend_ff;
						nxt_fpend = 1'b0;
						nxt_cur = fpend_ff ? fill_ff : song_mem[{song_ff, 5'h0}];
					end
					else if (cact_ff)
					begin
						nxt_cidx = 3'h0;
						nxt_cur = {cbank_ff, chain_ff[0]};
					end
				end
			end
		end

		// Triggers: live drums, then the running pattern
		if (!b.mode && (mode_ff == DSQ_M_DRUMS || (mode_ff == DSQ_M_PATS && ovl_ff && !b.sec)))
		begin
			if (mode_ff == DSQ_M_DRUMS && tempo_ff)
				nxt_trig = tempo_tick_i ? b.sel : 8'h00;
			else
				nxt_trig = e.sel;
		end
		if (run_ff && tempo_tick_i)
			nxt_trig = nxt_trig | pat_mem[{cur_ff, step_ff}];
	end

	// ==========================================
	// Blink timebase for pending picks and stops
	always_comb
	begin
		nxt_bcnt = bcnt_ff + 24'h1;
		nxt_blink = blink_ff;
		if (bcnt_ff >= 24'(BLINK_CYCLES - 1))
		begin
			nxt_bcnt = 24'h0;
			nxt_blink = !blink_ff;
		end
	end

	// ==========================================
	// Lamp selection
	always_comb
	begin
		nxt_led = '0;
		nxt_led.half = run_ff && step_ff[3];
		nxt_led.run = run_ff && (!stopq_ff || blink_ff);
		case (mode_ff)
			DSQ_M_DRUMS: nxt_led.tog = tempo_ff;
			DSQ_M_PATS: nxt_led.tog = ovl_ff;
			DSQ_M_SONGS: nxt_led.tog = fsel_ff;
			default: nxt_led.tog = 1'b0;
		endcase
		if (b.mode)
			nxt_led.sel = mode_ff;
		else if (b.sec && (mode_ff == DSQ_M_PATS || (mode_ff == DSQ_M_SONGS && fsel_ff)))
			nxt_led.sel = SEL_ONE << pbank_ff;
		else if (b.sec && mode_ff == DSQ_M_SONGS)
			nxt_led.sel = SEL_ONE << sbank_ff;
		else if (mode_ff == DSQ_M_PATS && !ovl_ff)
		begin
			if (cur_ff[5:3] == pbank_ff)
				nxt_led.sel = SEL_ONE << cur_ff[2:0];
			if (ppend_ff && blink_ff && npat_ff[5:3] == pbank_ff)
				nxt_led.sel = nxt_led.sel | (SEL_ONE << npat_ff[2:0]);
		end
		else if (mode_ff == DSQ_M_SONGS && fsel_ff)
		begin
			if (fpend_ff && blink_ff)
				nxt_led.sel = SEL_ONE << fill_ff[2:0];
		end
		else if (mode_ff == DSQ_M_SONGS)
		begin
			if (song_ff[3] == sbank_ff)
				nxt_led.sel = SEL_ONE << song_ff[2:0];
			if (spend_ff && blink_ff && snew_ff[3] == sbank_ff)
				nxt_led.sel = nxt_led.sel | (SEL_ONE << snew_ff[2:0]);
		end
		else
			nxt_led.sel = b.sel;
	end

	// ==========================================
	// Registers
	always_ff @(posedge sys_clk_i)
	begin
		if (!rstn_i)
		begin
			mode_ff <= DSQ_M_DRUMS;
			tempo_ff <= 1'b0;
			ovl_ff <= 1'b0;
			fsel_ff <= 1'b0;
			run_ff <= 1'b0;
			stopq_ff <= 1'b0;
			sply_ff <= 1'b0;
			pbank_ff <= 3'h0;
			cbank_ff <= 3'h0;
			sbank_ff <= 1'b0;
			step_ff <= 4'h0;
			cur_ff <= 6'h00;
			npat_ff <= 6'h00;
			ppend_ff <= 1'b0;
			chain_ff <= '{default: 3'h0};
			clen_ff <= 4'h0;
			bld_ff <= 4'h0;
			cidx_ff <= 3'h0;
			cact_ff <= 1'b0;
			cpend_ff <= 1'b0;
			song_ff <= 4'h0;
			snew_ff <= 4'h0;
			spend_ff <= 1'b0;
			spos_ff <= 5'h0;
			fill_ff <= 6'h00;
			fpend_ff <= 1'b0;
			infill_ff <= 1'b0;
			intro_ff <= 1'b0;
			trig_ff <= 8'h00;
			led_ff <= '0;
			bcnt_ff <= 24'h0;
			blink_ff <= 1'b0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			tempo_ff <= nxt_tempo;
			ovl_ff <= nxt_ovl;
			fsel_ff <= nxt_fsel;
			run_ff <= nxt_run;
			stopq_ff <= nxt_stopq;
			sply_ff <= nxt_sply;
			pbank_ff <= nxt_pbank;
			cbank_ff <= nxt_cbank;
			sbank_ff <= nxt_sbank;
			step_ff <= nxt_step;
			cur_ff <= nxt_cur;
			npat_ff <= nxt_npat;
			ppend_ff <= nxt_ppend;
			chain_ff <= nxt_chain;
			clen_ff <= nxt_clen;
			bld_ff <= nxt_bld;
			cidx_ff <= nxt_cidx;
			cact_ff <= nxt_cact;
			cpend_ff <= nxt_cpend;
			song_ff <= nxt_song;
			snew_ff <= nxt_snew;
			spend_ff <= nxt_spend;
			spos_ff <= nxt_spos;
			fill_ff <= nxt_fill;
			fpend_ff <= nxt_fpend;
			infill_ff <= nxt_infill;
			intro_ff <= nxt_intro;
			trig_ff <= nxt_trig;
			led_ff <= nxt_led;
			bcnt_ff <= nxt_bcnt;
			blink_ff <= nxt_blink;
		end
	end

	assign trig_o = trig_ff;
	assign led_o = led_ff;

	// ==========================================
	// Checks
	// Lamp is registered, so it shows the mode of one cycle earlier
	chk_mode_led_one: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		$past(b.mode) && b.mode |-> $onehot(led_o.sel) && led_o.sel == $past(mode_ff))
		else $error("mode hold does not show one mode lamp");

	chk_half_led: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		run_ff && tempo_tick_i && step_ff == 4'h7 && !pat_end && !e.run |=> ##1 led_o.half)
		else $error("half lamp dark on step nine");

	chk_reset_mode: assert property (@(posedge sys_clk_i)
		!rstn_i |=> mode_ff == DSQ_M_DRUMS && !run_ff)
		else $error("reset did not enter drum mode");

	chk_drum_fire: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		mode_ff == DSQ_M_DRUMS && !tempo_ff && !b.mode && e.sel[0] |=> trig_o[0] ##1 !trig_o[0] || run_ff)
		else $error("immediate press did not fire once");

	chk_style_flip: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		mode_ff == DSQ_M_DRUMS && e.tog && !b.mode |=> tempo_ff != $past(tempo_ff) ##1 led_o.tog == tempo_ff)
		else $error("toggle did not flip trigger style");

	chk_tempo_fire: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		mode_ff == DSQ_M_DRUMS && tempo_ff && !b.mode && tempo_tick_i |=> (trig_o & $past(b.sel)) == $past(b.sel))
		else $error("held voice not fired on step");

	chk_step_adv: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		run_ff && tempo_tick_i && !pat_end && !e.run |=> step_ff == $past(step_ff) + 4'h1)
		else $error("step did not advance on tick");

	chk_stop_now: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		run_ff && e.run && b.tog && !b.mode |=> !run_ff && step_ff == $past(step_ff))
		else $error("toggle plus run did not stop at once");

	chk_stop_defer: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		run_ff && e.run && !b.tog && !b.mode && !pat_end |=> run_ff && stopq_ff)
		else $error("plain run stopped before pattern end");

	chk_pick_defer: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		ppend_ff && !pat_end && !e.run && !(mode_ff == DSQ_M_PATS && hit) |=> cur_ff == $past(cur_ff))
		else $error("pending pattern switched early");

endmodule

// file: verif/dsq_player.sv
// Player model: presses and releases the panel buttons as a person would.
// Assumes the bench calls apply() from its main sequence only, one at a time.
`timescale 1ns/10ps

module dsq_player
	import dsq_pkg::*;
(
	// Clock
	input wire logic sys_clk_i,
	// Button pins
	output dsq_btn_t btn_o
);

	// ==========================================
	// Buttons released at power-up, so reset sees no press edges
	initial
	begin
		btn_o = '0;
	end

	// Change pins just after an edge, then linger so every level is seen
	task automatic apply(input dsq_btn_t v);
		@(posedge sys_clk_i);
		#1;
		btn_o = v;
		repeat (6) @(posedge sys_clk_i);
	endtask

endmodule

// file: verif/tb_top.sv
// Self-checking bench for the drum sequencer control block.
// Assumes dsq_top from design/ and the player model in dsq_player.sv.
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
	$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); end end

module tb_top
	import dsq_pkg::*;
;

	// ==========================================
	// Signals and bookkeeping
	logic sys_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic tempo_tick_i = 1'b0;
	dsq_load_t load_i = '0;
	dsq_btn_t btn_i;
	dsq_btn_t cur;
	logic [7:0] trig_o;
	dsq_led_t led_o;
	logic [7:0] expq[$];
	logic [7:0] pat[16];
	logic [7:0] e;
	logic [7:0] m;
	logic [1:0] blink_seen;
	int pl[4] = '{1, 2, 3, 9};
	localparam logic [11:0] BT_RUN = 12'h100;
	localparam logic [11:0] BT_TOG = 12'h200;
	int miscompares = 0;
	int checks_done = 0;

	// Clock, 20 ns period
	always #10 sys_clk_i = ~sys_clk_i;

	// ==========================================
	// Design and the player at its buttons
	dsq_top #(.BLINK_CYCLES(4)) uut (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.btn_i(btn_i),
		.tempo_tick_i(tempo_tick_i),
		.load_i(load_i),
		.trig_o(trig_o),
		.led_o(led_o)
	);

	dsq_player ply (
		.sys_clk_i(sys_clk_i),
		.btn_o(btn_i)
	);

	// ==========================================
	// Helpers
	// Settle past the edge so outputs are read where they are stable
	task automatic press();
		ply.apply(cur);
		#2;
	endtask

	// Press a button set, then release everything
	task automatic tap(input logic [11:0] v);
		cur = v;
		press();
		cur = '0;
		press();
	endtask

	// Bench's own voice table for the short patterns
	function automatic logic [7:0] step_voices(input int p, input int s);
		return 8'(16 * p + s + 1);
	endfunction

	// Note the expected voices of each step, then step once
	task automatic play_steps(input int p, input int s0, input int n);
		for (int j = 0; j < n; j++)
		begin
			expq.push_back(step_voices(p, s0 + j));
			tick();
		end
	endtask

	// Watch one lamp bit for a while; report which levels it showed
	task automatic blinks(input int n, output logic [1:0] r);
		logic [10:0] lv;
		r = 2'b00;
		repeat (12)
		begin
			@(posedge sys_clk_i);
			#2;
			lv = led_o;
			r = r | {lv[n] === 1'b0, lv[n] === 1'b1};
		end
	endtask

	// One tempo pulse, then room for trigger and lamp to settle
	task automatic tick();
		@(posedge sys_clk_i);
		#1;
		tempo_tick_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		tempo_tick_i = 1'b0;
		repeat (4) @(posedge sys_clk_i);
		#2;
	endtask

	task automatic load(input logic [1:0] k, input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1;
		load_i = '{we: 1'b1, kind: k, addr: a, data: d};
		@(posedge sys_clk_i);
		#1;
		load_i = '0;
	endtask

	task automatic wrap_up();
		if (expq.size() != 0)
			miscompares++;
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================
	// Trigger watcher: every pulse must match the oldest expectation
	always @(posedge sys_clk_i)
	begin
		#2;
		if (rstn_i && trig_o !== 8'h00)
		begin
			e = (expq.size() != 0) ? expq.pop_front() : 8'h00;
			`CHK(trig_o, e)
		end
	end

	// Hang guard, long enough for the whole sequence
	initial
	begin
		repeat (60000) @(posedge sys_clk_i);
		miscompares++;
		wrap_up();
	end

	// ==========================================
	// Main sequence
	initial
	begin
		void'($urandom(49));
		cur = '0;
		repeat (10) @(posedge sys_clk_i);
		#1;
		rstn_i = 1'b1;
		repeat (3) @(posedge sys_clk_i);
		// Immediate style: one pulse per press, none while held
		for (int k = 0; k < 8; k++)
		begin
			expq.push_back(8'h01 << k);
			cur.sel = 8'h01 << k;
			press();
			repeat (10) @(posedge sys_clk_i);
			cur.sel = 8'h00;
			press();
		end
		expq.push_back(8'h81);
		cur.sel = 8'h81;
		press();
		cur.sel = 8'h00;
		press();
		// Tempo-locked style: random held set fires on every step
		cur.tog = 1'b1;
		press();
		cur.tog = 1'b0;
		press();
		`CHK(led_o.tog, 1'b1)
		m = 8'($urandom()) | 8'h01;
		cur.sel = m;
		press();
		for (int i = 0; i < 3; i++)
		begin
			expq.push_back(m);
			tick();
		end
		cur.sel = 8'h00;
		press();
		cur.tog = 1'b1;
		press();
		cur.tog = 1'b0;
		press();
		`CHK(led_o.tog, 1'b0)
		// Mode hold shows drums, then selector 2 picks pattern mode
		cur.mode = 1'b1;
		press();
		`CHK(led_o.sel, 8'h01)
		cur.sel = 8'h02;
		press();
		cur.sel = 8'h00;
		press();
		cur.mode = 1'b0;
		press();
		cur.mode = 1'b1;
		press();
		`CHK(led_o.sel, 8'h02)
		cur.mode = 1'b0;
		press();
		// Secondary hold shows bank 0
		cur.sec = 1'b1;
		press();
		`CHK(led_o.sel, 8'h01)
		cur.sec = 1'b0;
		press();
		// Random pattern 0, full sixteen steps
		for (int i = 0; i < 16; i++)
		begin
			pat[i] = 8'($urandom());
			load(LD_STEP, {6'h00, 4'(i)}, pat[i]);
		end
		load(LD_PLEN, 10'h000, 8'h0f);
		cur.run = 1'b1;
		press();
		cur.run = 1'b0;
		press();
		// Play past the wrap to see the loop
		for (int i = 0; i < 18; i++)
		begin
			if (pat[i % 16] != 8'h00)
				expq.push_back(pat[i % 16]);
			tick();
			if (i == 6)
				`CHK(led_o.half, 1'b0)
			if (i == 7)
				`CHK(led_o.half, 1'b1)
		end
		// Plain run: blink while pending, stop at pattern end
		cur.run = 1'b1;
		press();
		cur.run = 1'b0;
		press();
		blinks(0, blink_seen);
		`CHK(blink_seen, 2'b11)
		for (int i = 2; i < 19; i++)
		begin
			if (i < 16 && pat[i] != 8'h00)
				expq.push_back(pat[i]);
			tick();
		end
		`CHK(expq.size(), 0)
		// Short four-step patterns and two small songs
		foreach (pl[j])
		begin
			for (int s = 0; s < 4; s++)
				load(LD_STEP, {6'(pl[j]), 4'(s)}, step_voices(pl[j], s));
			load(LD_PLEN, 10'(pl[j]), 8'h03);
		end
		load(LD_SONG, 10'h000, 8'h01);
		load(LD_SONG, 10'h001, 8'h02);
		load(LD_SONG, 10'h002, 8'h03);
		load(LD_SONG, 10'h020, 8'h02);
		load(LD_SLEN, 10'h000, 8'h03);
		load(LD_SLEN, 10'h001, 8'h01);
		// Pick while stopped, then a deferred pick while running
		tap(12'h002);
		`CHK(led_o.sel, 8'h02)
		tap(BT_RUN);
		play_steps(1, 0, 2);
		tap(12'h004);
		blinks(5, blink_seen);
		`CHK(blink_seen, 2'b11)
		play_steps(1, 2, 2);
		play_steps(2, 0, 1);
		`CHK(led_o.sel, 8'h04)
		// Drum overlay over the running pattern
		tap(BT_TOG);
		`CHK(led_o.tog, 1'b1)
		expq.push_back(8'h80);
		tap(12'h080);
		play_steps(2, 1, 1);
		tap(BT_TOG);
		// Toggle plus run: stop now, then resume where it stopped
		cur = BT_TOG;
		press();
		cur = BT_TOG | BT_RUN;
		press();
		cur = '0;
		press();
		`CHK(led_o.run, 1'b0)
		tick();
		cur = BT_TOG;
		press();
		cur = BT_TOG | BT_RUN;
		press();
		cur = '0;
		press();
		play_steps(2, 2, 2);
		tap(BT_RUN);
		play_steps(2, 0, 4);
		`CHK(led_o.run, 1'b0)
		// Chain 3, 1, 2 built while stopped, started by run
		cur.sel = 8'h08;
		press();
		cur.sel = 8'h0a;
		press();
		cur.sel = 8'h0e;
		press();
		cur.sel = 8'h00;
		press();
		`CHK(led_o.sel, 8'h08)
		tap(BT_RUN);
		play_steps(3, 0, 4);
		play_steps(1, 0, 4);
		play_steps(2, 0, 4);
		play_steps(3, 0, 1);
		tap(BT_TOG);
		expq.push_back(8'h40);
		tap(12'h040);
		play_steps(3, 1, 1);
		tap(BT_TOG);
		tap(BT_RUN);
		play_steps(3, 2, 2);
		// Song mode: banks, intro, fill and a deferred song pick
		cur.mode = 1'b1;
		press();
		cur.sel = 8'h04;
		press();
		cur = '0;
		press();
		cur.sec = 1'b1;
		press();
		`CHK(led_o.sel, 8'h01)
		cur.sel = 8'h04;
		press();
		cur.sel = 8'h06;
		press();
		`CHK(led_o.sel, 8'h02)
		cur.sel = 8'h00;
		press();
		cur.sel = 8'h01;
		press();
		cur = '0;
		press();
		tap(12'h001);
		`CHK(led_o.sel, 8'h01)
		tap(BT_TOG);
		`CHK(led_o.tog, 1'b1)
		cur.sec = 1'b1;
		press();
		cur.sel = 8'h02;
		press();
		`CHK(led_o.sel, 8'h02)
		cur = '0;
		press();
		tap(12'h002);
		tap(BT_RUN);
		play_steps(9, 0, 4);
		play_steps(1, 0, 4);
		play_steps(2, 0, 2);
		tap(12'h002);
		play_steps(2, 2, 2);
		play_steps(9, 0, 4);
		play_steps(3, 0, 1);
		tap(BT_TOG);
		tap(12'h002);
		blinks(4, blink_seen);
		`CHK(blink_seen, 2'b11)
		play_steps(3, 1, 3);
		play_steps(2, 0, 1);
		`CHK(led_o.sel, 8'h02)
		`CHK(expq.size(), 0)
		wrap_up();
	end

endmodule
